/* File: logic/brt_engine.sv */
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// - Control bits 1:0 select run-test operation
// - Operate only in run-test instruction, Run-Test/Idle
// - Enable cells excluded from all algorithms
// - Enable cells still gate output drive
// - Sample/toggle: capture inputs rising, shadow update
// - Sample/toggle: invert outputs rising, latch falling
// - Pattern: step 16-bit generator, drive falling
// - Pattern values also feed core input shadows
// - All-zero generator stays all zero
// - Signature: fold inputs into 16 bits
// - Signature: output shadows held unchanged
// - Combined: 8-bit input signature, shadows updated
// - Combined: 8-bit output pattern, drive falling
// - Sample TDI, TMS, inputs on TCK rising
// - TDO and test-mode outputs change on TCK falling
// - Capture-IR loads 10000001
// - Serial data through TDI/TDO in shift states
// - Run-test selects bypass, captures 0, test mode

module brt_engine #(
  parameter int IN_W = 8,
  parameter int HADDR_W = 32
) (
  input wire logic REF_CLK, // System clock, 10 MHz
  input wire logic RST_B, // Async reset, active low
  input wire logic TCK, // Test clock pin
  input wire logic TMS, // Test mode select pin
  input wire logic TDI, // Test data in pin
  input wire logic [7:0] A, // Buffer data inputs
  input wire logic [1:0] OE_B, // Group enables, active low
  output logic [7:0] Y, // Buffer data outputs
  output logic [1:0] Y_OE, // Group drive enables
  output logic TDO, // Test data out
  output logic TDO_OE, // Test data out enable
  input wire logic HSEL, // Slave select
  input wire logic [HADDR_W-1:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write strobe
  input wire logic [2:0] HSIZE, // Transfer size
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  output logic [31:0] HRDATA, // Read data
  output logic HREADYOUT, // Slave ready
  output logic HRESP // Response, always OKAY
);

  // ========================================================
  // Elaboration checks
  if (IN_W != 8) begin : g_bad_width
    $error("brt_engine supports exactly eight buffer bits");
  end
  if (HADDR_W < 8) begin : g_bad_addr
    $error("brt_engine needs at least eight address bits");
  end

  // ========================================================
  // Helpers
  function automatic brt_pkg::brt_tap_e tap_next(input brt_pkg::brt_tap_e st,
                                                 input logic tms);
    brt_pkg::brt_tap_e nx;
    nx = st;
    // Reset, idle and data-register branch
    case (st)
      brt_pkg::TAP_TLR: begin
        nx = tms ? brt_pkg::TAP_TLR : brt_pkg::TAP_RTI;
      end
      brt_pkg::TAP_RTI: begin
        nx = tms ? brt_pkg::TAP_SELDR : brt_pkg::TAP_RTI;
      end
      brt_pkg::TAP_SELDR: begin
        nx = tms ? brt_pkg::TAP_SELIR : brt_pkg::TAP_CAPDR;
      end
      brt_pkg::TAP_CAPDR: begin
        nx = tms ? brt_pkg::TAP_EX1DR : brt_pkg::TAP_SHDR;
      end
      brt_pkg::TAP_SHDR: begin
        nx = tms ? brt_pkg::TAP_EX1DR : brt_pkg::TAP_SHDR;
      end
      brt_pkg::TAP_EX1DR: begin
        nx = tms ? brt_pkg::TAP_UPDR : brt_pkg::TAP_PADR;
      end
      brt_pkg::TAP_PADR: begin
        nx = tms ? brt_pkg::TAP_EX2DR : brt_pkg::TAP_PADR;
      end
      brt_pkg::TAP_EX2DR: begin
        nx = tms ? brt_pkg::TAP_UPDR : brt_pkg::TAP_SHDR;
      end
      brt_pkg::TAP_UPDR: begin
        nx = tms ? brt_pkg::TAP_SELDR : brt_pkg::TAP_RTI;
      end
      // Instruction-register branch
      brt_pkg::TAP_SELIR: begin
        nx = tms ? brt_pkg::TAP_TLR : brt_pkg::TAP_CAPIR;
      end
      brt_pkg::TAP_CAPIR: begin
        nx = tms ? brt_pkg::TAP_EX1IR : brt_pkg::TAP_SHIR;
      end
      brt_pkg::TAP_SHIR: begin
        nx = tms ? brt_pkg::TAP_EX1IR : brt_pkg::TAP_SHIR;
      end
      brt_pkg::TAP_EX1IR: begin
        nx = tms ? brt_pkg::TAP_UPIR : brt_pkg::TAP_PAIR;
      end
      brt_pkg::TAP_PAIR: begin
        nx = tms ? brt_pkg::TAP_EX2IR : brt_pkg::TAP_PAIR;
      end
      brt_pkg::TAP_EX2IR: begin
        nx = tms ? brt_pkg::TAP_UPIR : brt_pkg::TAP_SHIR;
      end
      brt_pkg::TAP_UPIR: begin
        nx = tms ? brt_pkg::TAP_SELDR : brt_pkg::TAP_RTI;
      end
      // Unused codes fall back to reset rather than lock up
      default: begin
        nx = brt_pkg::TAP_TLR;
      end
    endcase
    return nx;
  endfunction

  // Taps x^16+x^14+x^13+x^11+1; zero feeds back zero
  function automatic logic [15:0] lfsr16(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Taps x^8+x^6+x^5+x^4+1; zero feeds back zero
  function automatic logic [7:0] lfsr8(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // ========================================================
  // State
  brt_pkg::brt_state_s s_r;
  brt_pkg::brt_state_s s_nxt;

  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  logic [7:0] a_in;
  logic [1:0] oe_in;
  logic [6:0] op;
  logic is_run_selected_test;
  logic sel_bsr;
  logic sel_bcr;
  logic test_mode;
  logic [7:0] in_sh;
  logic [7:0] out_sh;

  always_comb begin
    s_nxt = s_r;
    // Two-stage synchronisers; only stage 1 is read by logic
    s_nxt.tck_s = {s_r.tck_s[0], TCK};
    s_nxt.tms_s = {s_r.tms_s[0], TMS};
    s_nxt.tdi_s = {s_r.tdi_s[0], TDI};
    s_nxt.a_s = {s_r.a_s[0], A};
    s_nxt.oe_s = {s_r.oe_s[0], OE_B};
    s_nxt.tck_d = s_r.tck_s[1];
    // Disabling the port freezes the TAP but keeps the buffer alive
    rise = s_r.tck_s[1] & ~s_r.tck_d & s_r.ctrl_en;
    fall = ~s_r.tck_s[1] & s_r.tck_d & s_r.ctrl_en;
    tms = s_r.tms_s[1];
    tdi = s_r.tdi_s[1];
    a_in = s_r.a_s[1];
    oe_in = s_r.oe_s[1];
    op = s_r.ir[6:0];
    is_run_selected_test = (op == `BRT_OP_RUN_SELECTED_TEST);
    sel_bsr = (op == `BRT_OP_SAMPLE) || (op == `BRT_OP_EXTEST);
    sel_bcr = (op == `BRT_OP_CONTROL_REG_SCAN_NORMAL) || (op == `BRT_OP_SCANCT);
    test_mode = is_run_selected_test || (op == `BRT_OP_EXTEST) || (op == `BRT_OP_SCANCT);
    in_sh = s_r.boundary_scan_chain[`BRT_IN_LSB +: 8];
    out_sh = s_r.boundary_scan_chain[`BRT_OUT_LSB +: 8];

    // ======================================================
    // TCK rising edge: sample, shift, capture, run
    if (rise) begin
      case (s_r.tap)
        brt_pkg::TAP_CAPIR: begin
          s_nxt.ir_sh = `BRT_IR_CAPTURE;
        end
        brt_pkg::TAP_SHIR: begin
          s_nxt.ir_sh = {tdi, s_r.ir_sh[`BRT_IR_W-1:1]};
        end
        brt_pkg::TAP_CAPDR: begin
          s_nxt.byp = 1'b0;
          if (sel_bsr) begin
            s_nxt.boundary_scan_chain = {oe_in, a_in, a_in};
          end
        end
        brt_pkg::TAP_SHDR: begin
          if (sel_bsr) begin
            s_nxt.boundary_scan_chain = {tdi, s_r.boundary_scan_chain[`BRT_BSR_W-1:1]};
          end else if (sel_bcr) begin
            s_nxt.bcr_sh = {tdi, s_r.bcr_sh[`BRT_BCR_W-1:1]};
          end else begin
            s_nxt.byp = tdi;
          end
        end
        brt_pkg::TAP_RTI: begin
          // Enable cells 17:16 are never touched here
          if (is_run_selected_test) begin
            case (s_r.boundary_control_register)
              `BRT_BCR_TOGGLE: begin
                s_nxt.boundary_scan_chain[`BRT_IN_LSB +: 8] = a_in;
                s_nxt.boundary_scan_chain[`BRT_OUT_LSB +: 8] = ~out_sh;
              end
              `BRT_BCR_PRPG16: begin
                s_nxt.boundary_scan_chain[15:0] = lfsr16(s_r.boundary_scan_chain[15:0]);
              end
              `BRT_BCR_PSA16: begin
                s_nxt.boundary_scan_chain[15:0] = lfsr16(s_r.boundary_scan_chain[15:0]) ^ {8'h00, a_in};
              end
              `BRT_BCR_COMB8: begin
                s_nxt.boundary_scan_chain[`BRT_IN_LSB +: 8] = lfsr8(in_sh) ^ a_in;
                s_nxt.boundary_scan_chain[`BRT_OUT_LSB +: 8] = lfsr8(out_sh);
              end
              default: begin
                s_nxt.boundary_scan_chain = s_r.boundary_scan_chain;
              end
            endcase
          end
        end
        default: begin
          s_nxt.byp = s_r.byp;
        end
      endcase
      s_nxt.tap = tap_next(s_r.tap, tms);
    end

    // ======================================================
    // TCK falling edge: updates, TDO and test-mode pin changes
    if (fall) begin
      s_nxt.tdo_oe = (s_r.tap == brt_pkg::TAP_SHIR) || (s_r.tap == brt_pkg::TAP_SHDR);
      if (s_r.tap == brt_pkg::TAP_SHIR) begin
        s_nxt.tdo = s_r.ir_sh[0];
      end else if (sel_bsr) begin
        s_nxt.tdo = s_r.boundary_scan_chain[0];
      end else if (sel_bcr) begin
        s_nxt.tdo = s_r.bcr_sh[0];
      end else begin
        s_nxt.tdo = s_r.byp;
      end
      case (s_r.tap)
        brt_pkg::TAP_TLR: begin
          s_nxt.ir = `BRT_IR_RESET;
        end
        brt_pkg::TAP_UPIR: begin
          s_nxt.ir = s_r.ir_sh;
        end
        brt_pkg::TAP_UPDR: begin
          if (sel_bsr) begin
            s_nxt.shd = s_r.boundary_scan_chain;
          end else if (sel_bcr) begin
            s_nxt.boundary_control_register = s_r.bcr_sh;
          end
        end
        brt_pkg::TAP_RTI: begin
          if (is_run_selected_test) begin
            s_nxt.shd[`BRT_IN_LSB +: 8] = in_sh;
            if (s_r.boundary_control_register != `BRT_BCR_PSA16) begin
              s_nxt.shd[`BRT_OUT_LSB +: 8] = out_sh;
            end
            // Signature mode leaves output shadows as they were
          end
        end
        default: begin
          s_nxt.shd = s_r.shd;
        end
      endcase
      if (test_mode) begin
        s_nxt.y = s_nxt.shd[`BRT_OUT_LSB +: 8];
        s_nxt.y_oe = ~s_nxt.shd[`BRT_OE_LSB +: 2];
      end
    end
    if (!test_mode) begin
      // Normal buffer path runs on the system clock
      s_nxt.y = a_in;
      s_nxt.y_oe = ~oe_in;
    end

    // ======================================================
    // AHB-Lite slave, zero wait states
    if (s_r.hsel_q && s_r.hwr_q && s_r.hidx_q == `BRT_IDX_CTRL) begin
      s_nxt.ctrl_en = HWDATA[`BRT_CTRL_EN_BIT];
    end
    s_nxt.hsel_q = HSEL & HREADY & HTRANS[1];
    s_nxt.hwr_q = HWRITE;
    s_nxt.hidx_q = HADDR[`BRT_ADDR_LSB +: `BRT_IDX_W];
    s_nxt.hrdata = 32'h0000_0000;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      // Read data is a snapshot; a TCK edge in the same cycle shows next time
      case (HADDR[`BRT_ADDR_LSB +: `BRT_IDX_W])
        `BRT_IDX_CTRL: begin
          s_nxt.hrdata = {31'h0000_0000, s_r.ctrl_en};
        end
        `BRT_IDX_STATUS: begin
          s_nxt.hrdata = {17'h0_0000, test_mode, s_r.boundary_control_register, s_r.ir, s_r.tap};
        end
        `BRT_IDX_CHAIN: begin
          s_nxt.hrdata = {14'h0000, s_r.boundary_scan_chain};
        end
        `BRT_IDX_SHADOW: begin
          s_nxt.hrdata = {14'h0000, s_r.shd};
        end
        default: begin
          s_nxt.hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= '0;
      s_r.tap <= brt_pkg::TAP_TLR;
      s_r.ir <= `BRT_IR_RESET;
      s_r.boundary_control_register <= `BRT_BCR_RESET;
      s_r.ctrl_en <= `BRT_CTRL_EN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================
  // Outputs
  assign Y = s_r.y;
  assign Y_OE = s_r.y_oe;
  assign TDO = s_r.tdo;
  assign TDO_OE = s_r.tdo_oe;
  assign HRDATA = s_r.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

endmodule

/* File: logic/brt_params.svh */
`ifndef BRT_PARAMS_SVH
`define BRT_PARAMS_SVH

// ==========================================================
// Chain layout: inputs 7:0, outputs 15:8, enables 17:16
`define BRT_BSR_W 18
`define BRT_IN_LSB 0
`define BRT_OUT_LSB 8
`define BRT_OE_LSB 16
`define BRT_IR_W 8
`define BRT_BCR_W 2

// ==========================================================
// Instruction codes, bit 7 ignored
`define BRT_IR_CAPTURE 8'h81
`define BRT_IR_RESET 8'hFF
`define BRT_OP_SAMPLE 7'h02
`define BRT_OP_EXTEST 7'h03
`define BRT_OP_RUN_SELECTED_TEST 7'h09
`define BRT_OP_CONTROL_REG_SCAN_NORMAL 7'h0E
`define BRT_OP_SCANCT 7'h0F

// ==========================================================
// Control register operation codes
`define BRT_BCR_TOGGLE 2'h0
`define BRT_BCR_PRPG16 2'h1
`define BRT_BCR_PSA16 2'h2
`define BRT_BCR_COMB8 2'h3
`define BRT_BCR_RESET 2'h0

// ==========================================================
// Bus map, word index = byte address bits 7:2
`define BRT_ADDR_LSB 2
`define BRT_IDX_W 6
`define BRT_IDX_CTRL 6'h00
`define BRT_IDX_STATUS 6'h01
`define BRT_IDX_CHAIN 6'h02
`define BRT_IDX_SHADOW 6'h03
`define BRT_CTRL_EN_BIT 0
`define BRT_CTRL_EN_RESET 1'h1

`endif

/* File: logic/brt_pkg.sv */
`include "brt_params.svh"

package brt_pkg;

  // ========================================================
  // TAP controller states
  typedef enum logic [3:0] {
    TAP_EX2DR = 4'h0,
    TAP_EX1DR = 4'h1,
    TAP_SHDR = 4'h2,
    TAP_PADR = 4'h3,
    TAP_SELIR = 4'h4,
    TAP_UPDR = 4'h5,
    TAP_CAPDR = 4'h6,
    TAP_SELDR = 4'h7,
    TAP_EX2IR = 4'h8,
    TAP_EX1IR = 4'h9,
    TAP_SHIR = 4'hA,
    TAP_PAIR = 4'hB,
    TAP_RTI = 4'hC,
    TAP_UPIR = 4'hD,
    TAP_CAPIR = 4'hE,
    TAP_TLR = 4'hF
  } brt_tap_e;

  // ========================================================
  // Whole engine state
  typedef struct packed {
    logic [1:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0][7:0] a_s;
    logic [1:0][1:0] oe_s;
    logic tck_d;
    brt_tap_e tap;
    logic [`BRT_IR_W-1:0] ir_sh;
    logic [`BRT_IR_W-1:0] ir;
    logic byp;
    logic [`BRT_BCR_W-1:0] bcr_sh;
    logic [`BRT_BCR_W-1:0] boundary_control_register;
    logic [`BRT_BSR_W-1:0] boundary_scan_chain;
    logic [`BRT_BSR_W-1:0] shd;
    logic tdo;
    logic tdo_oe;
    logic [7:0] y;
    logic [1:0] y_oe;
    logic ctrl_en;
    logic hsel_q;
    logic hwr_q;
    logic [`BRT_IDX_W-1:0] hidx_q;
    logic [31:0] hrdata;
  } brt_state_s;

endpackage

/* File: dv/brt_engine_asserts.sv */
`timescale 1ns/1ps
// ====================================
// Bus and test port checks
module brt_engine_checker #(
  parameter int HADDR_W = 32
) (
  input wire logic REF_CLK, // Clock
  input wire logic RST_B, // Reset, low
  input wire logic TCK, // Test clock
  input wire logic TDO, // Test data
  input wire logic TDO_OE, // Test data drive
  input wire logic HSEL, // Select
  input wire logic [HADDR_W-1:0] HADDR, // Address
  input wire logic [1:0] HTRANS, // Transfer
  input wire logic HWRITE, // Write
  input wire logic HREADY, // Ready in
  input wire logic [31:0] HRDATA, // Read data
  input wire logic HREADYOUT, // Ready out
  input wire logic HRESP // Response
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  wire logic rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
  wire logic [5:0] idx = HADDR[7:2];
  ready_high_a: assert property (HREADYOUT)
    else $error("ready low");
  resp_okay_a: assert property (!HRESP)
    else $error("error response");
  // The pin fall is seen late, but well inside the low half period
  tdo_fall_a: assert property ($changed(TDO) |-> !TCK)
    else $error("TDO moved while test clock high");
  tdo_drive_a: assert property ($changed(TDO_OE) |-> !TCK)
    else $error("TDO drive moved while test clock high");
  idle_data_a: assert property (!$past(rd) |-> HRDATA == 32'h0)
    else $error("read data outside data phase");
  unmapped_zero_a: assert property ($past(rd) && $past(idx) > 6'h03 |-> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  ctrl_width_a: assert property ($past(rd) && $past(idx) == 6'h00 |-> HRDATA[31:1] == 31'h0)
    else $error("control read wider than one bit");
  status_width_a: assert property ($past(rd) && $past(idx) == 6'h01 |-> HRDATA[31:15] == 17'h0)
    else $error("status upper bits set");
endmodule

bind brt_engine brt_engine_checker #(.HADDR_W(HADDR_W)) u_chk (.REF_CLK(REF_CLK),
  .RST_B(RST_B), .TCK(TCK), .TDO(TDO), .TDO_OE(TDO_OE), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP));

/* File: dv/brt_tester.sv */
`timescale 1ns/1ps
// ====================================
// Boundary-scan tester model
module brt_tester (
  input wire logic clk, // Bench clock
  input wire logic tdo, // Serial data from device
  output logic tck, // Test clock, 800 ns
  output logic tms, // Mode select
  output logic tdi // Serial data to device
);
  logic tdo_seen;
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // Mode and data change on the fall, device takes them on the rise
  task automatic step(input logic m, input logic d);
    @(posedge clk);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tdo_seen = tdo;
    tck <= 1'h1;
    repeat (3) @(posedge clk);
  endtask
  task automatic fall_only();
    @(posedge clk);
    tck <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  // From Run-Test/Idle back to it; seed loaded before any run
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout);
    dout = 18'h0;
    step(1'h1, 1'h1);
    if (ir) begin
      step(1'h1, 1'h1);
    end
    step(1'h0, 1'h1);
    step(1'h0, 1'h1);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = tdo_seen;
    end
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
  endtask
endmodule

/* File: dv/boundary_run_test_engine_test.sv */
`timescale 1ns/1ps
// ====================================
// Run-test engine bench
module boundary_run_test_engine_test;
  logic REF_CLK = 1'h0;
  logic RST_B = 1'h0;
  logic HSEL = 1'h0;
  logic HWRITE = 1'h0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [7:0] A = 8'h5A;
  logic [1:0] OE_B = 2'h2;
  logic [31:0] rdv;
  wire logic TCK, TMS, TDI, TDO, TDO_OE, HREADYOUT, HRESP;
  wire logic [7:0] Y;
  wire logic [1:0] Y_OE;
  wire logic [31:0] HRDATA;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 REF_CLK = ~REF_CLK;
  brt_engine dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .A(A), .OE_B(OE_B), .Y(Y), .Y_OE(Y_OE), .TDO(TDO), .TDO_OE(TDO_OE), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
  brt_tester u_tst (.clk(REF_CLK), .tdo(TDO), .tck(TCK), .tms(TMS), .tdi(TDI));
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Whole run needs about 3700 cycles
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge REF_CLK);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, addr};
    HWRITE <= wr;
    @(posedge REF_CLK);
    while (!HREADYOUT) @(posedge REF_CLK);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge REF_CLK);
    while (!HREADYOUT) @(posedge REF_CLK);
    rd = HRDATA;
  endtask
  task automatic reg_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'h0, addr, 32'h0, rd);
    chk(what, rd, exp);
  endtask
  task automatic ir_scan(input logic [7:0] code);
    logic [17:0] got;
    u_tst.scan(1'h1, 8, {10'h0, code}, got);
    chk("ir capture", {24'h0, got[7:0]}, 32'h81);
  endtask
  function automatic logic [15:0] lf16(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] lf8(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic run_case(input logic [1:0] op, input logic [17:0] seed);
    logic [17:0] ch;
    logic [17:0] sh;
    logic [17:0] got;
    ch = seed;
    ir_scan(8'h02);
    u_tst.scan(1'h0, 18, seed, got);
    chk("capture", {14'h0, got}, {14'h0, OE_B, A, A});
    ir_scan(8'h0E);
    u_tst.scan(1'h0, 2, {16'h0, op}, got);
    ir_scan(8'h09);
    for (int i = 0; i < 12; i++) begin
      u_tst.step(1'h0, 1'h1);
      case (op)
        2'h0: ch[15:0] = {~ch[15:8], A};
        2'h1: ch[15:0] = lf16(ch[15:0]);
        2'h2: ch[15:0] = lf16(ch[15:0]) ^ {8'h00, A};
        default: ch[15:0] = {lf8(ch[15:8]), lf8(ch[7:0]) ^ A};
      endcase
    end
    u_tst.fall_only();
    sh = (op == 2'h2) ? {ch[17:16], seed[15:8], ch[7:0]} : ch;
    reg_chk("chain", 8'h08, {14'h0, ch});
    reg_chk("shadow", 8'h0C, {14'h0, sh});
    reg_chk("status", 8'h04, {17'h0, 1'h1, op, 8'h09, 4'hC});
    chk("outputs", {24'h0, Y}, {24'h0, sh[15:8]});
    chk("drive", {30'h0, Y_OE}, {30'h0, ~seed[17:16]});
    u_tst.scan(1'h0, 1, 18'h1, got);
    chk("bypass", {31'h0, got[0]}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK);
    RST_B <= 1'h1;
    repeat (6) @(posedge REF_CLK);
    chk("normal out", {24'h0, Y}, {24'h0, A});
    chk("normal drive", {30'h0, Y_OE}, {30'h0, ~OE_B});
    reg_chk("ctrl", 8'h00, 32'h1);
    reg_chk("status", 8'h04, 32'hFFF);
    reg_chk("unmapped", 8'h40, 32'h0);
    bus(1'h1, 8'h00, 32'h0, rdv);
    reg_chk("ctrl off", 8'h00, 32'h0);
    u_tst.step(1'h0, 1'h1);
    reg_chk("frozen tap", 8'h04, 32'hFFF);
    bus(1'h1, 8'h00, 32'h1, rdv);
    u_tst.step(1'h0, 1'h1);
    run_case(2'h0, 18'h1A53C);
    run_case(2'h1, 18'h1C3A5);
    run_case(2'h2, 18'h2B1E7);
    run_case(2'h3, 18'h093D6);
    run_case(2'h1, 18'h10000);
    stop_test();
  end
endmodule
